// ==== rtl/qpx_expander.sv ====
// Bus slave end: sixteen quasi-bidirectional port lines with change interrupt.
// Functional notes
// - All lines high, weak pullup after power-up.
// - Written-high lines get strong pullup until SCL falls.
// - Input edge on any line asserts interrupt.
// - Interrupt clears on data return or access.
// - Read clears after rise, write after fall.
// - Re-arm after clear; foreign traffic no effect.
// - No registers; data goes straight to ports.
// - Even byte count; low byte then high.
// - Write: address, low, high, acked, then output.
// - Unlimited pairs per write; each pair replaces.
// - Read returns sampled pin levels per byte.
// - Master writes ones before reading inputs.
// - Held reset until release; bus idle after.
// - Three select pins set low address bits.
// - Select pins stable between Start and Stop.
// - Start is SDA fall with SCL high.
// - General call address ignored, never acknowledged.
// - Acknowledge holds SDA low through ninth pulse.
// - Outputs change only from acked bytes, at ack.
// - SDA change during SCL high is control; only the fall (Start) is detected, a Stop is not.
// - Master nacks last byte; slave releases SDA.
// - Address is 0100 then the select pins.
`timescale 1ns/10ps
`default_nettype none
module qpx_expander (
    qpx_link_if.device       lnk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [2:0]  addr_select_pins,
    input  wire logic [15:0] port_lines_in,
    output logic      [15:0] port_lines_drive_low,
    output logic      [15:0] port_lines_strong_up
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } qpx_dev_st_t;

    typedef struct packed {
        qpx_dev_st_t st;
        logic [2:0]  bit_cnt;
        logic [7:0]  sh;
        logic        hi;
        logic [7:0]  low_hold;
        logic [15:0] latch;
        logic [15:0] snap;
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic        drive_nxt;
        logic        start_seen;
        logic        upd_tgl;
        logic        wr_clr;
    } qpx_dev_t;

    qpx_dev_t r;
    qpx_dev_t next_r;

    logic       sda_oe;
    logic       upd_seen;
    logic       int_hold;
    logic       start_tgl;
    logic       int_raw;
    logic [7:0] byte_in;
    logic [7:0] pin_byte;

    // Falling-edge side: SDA drive, end of strong pullup, Start detection.
    qpx_scl_neg u_neg (
        .scl       (lnk.scl),
        .sda       (lnk.sda),
        .rstn      (rstn),
        .ce        (ce),
        .drive_nxt (r.drive_nxt),
        .upd_tgl   (r.upd_tgl),
        .int_raw   (int_raw),
        .sda_oe    (sda_oe),
        .upd_seen  (upd_seen),
        .int_hold  (int_hold),
        .start_tgl (start_tgl)
    );

    // Incoming byte and the pin byte that a read returns next.
    assign byte_in  = {r.sh[6:0], lnk.sda};
    assign pin_byte = r.hi ? r.pin_s2[15:8] : r.pin_s2[7:0];

    // Rising-edge bus engine: samples SDA and decides the next drive level.
    always_comb begin
        next_r = r;
        if (ce) begin
            next_r.pin_s1 = port_lines_in;
            next_r.pin_s2 = r.pin_s1;
            next_r.wr_clr = 1'b0;
            if (start_tgl != r.start_seen) begin
                // First address bit follows any Start, even mid-transfer.
                next_r.start_seen = start_tgl;
                next_r.st         = ST_ADDR;
                next_r.sh         = {7'h00, lnk.sda};
                next_r.bit_cnt    = 3'h1;
                next_r.drive_nxt  = 1'b0;
            end else begin
                case (r.st)
                    ST_ADDR: begin
                        next_r.sh      = byte_in;
                        next_r.bit_cnt = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == 3'h7) begin
                            // Only our own address is answered; others go to ST_IDLE with latch and snapshot unchanged.
                            if (byte_in[7:1] == {qpx_pkg::ADDR_FIXED, addr_select_pins}
                                && byte_in[7:1] != qpx_pkg::ADDR_GCALL) begin
                                next_r.st        = ST_ADDR_ACK;
                                next_r.drive_nxt = 1'b1;
                            end else begin
                                next_r.st = ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        next_r.bit_cnt = 3'h0;
                        next_r.hi      = 1'b0;
                        if (r.sh[0]) begin
                            // Read: take the low pins at this ack clock.
                            next_r.sh        = r.pin_s2[7:0];
                            next_r.snap      = r.pin_s2;
                            next_r.hi        = 1'b1;
                            next_r.drive_nxt = ~r.pin_s2[7];
                            next_r.st        = ST_RDATA;
                        end else begin
                            next_r.drive_nxt = 1'b0;
                            next_r.st        = ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        next_r.sh      = byte_in;
                        next_r.bit_cnt = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == 3'h7) begin
                            next_r.st        = ST_WACK;
                            next_r.drive_nxt = 1'b1;
                        end
                    end
                    ST_WACK: begin
                        next_r.st        = ST_WDATA;
                        next_r.bit_cnt   = 3'h0;
                        next_r.drive_nxt = 1'b0;
                        if (!r.hi) begin
                            next_r.low_hold = r.sh;
                            next_r.hi       = 1'b1;
                        end else begin
                            // Whole pair acked: ports change at this rising edge.
                            next_r.latch   = {r.sh, r.low_hold};
                            next_r.upd_tgl = ~r.upd_tgl;
                            // Lines that were sunk low and are written high are taken as released high.
                            next_r.snap    = {r.sh, r.low_hold} & (r.pin_s2 | ~r.latch);
                            next_r.wr_clr  = 1'b1;
                            next_r.hi      = 1'b0;
                        end
                    end
                    ST_RDATA: begin
                        next_r.drive_nxt = ~r.sh[6];
                        next_r.sh        = {r.sh[6:0], 1'b0};
                        next_r.bit_cnt   = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == 3'h7) begin
                            next_r.drive_nxt = 1'b0;
                            next_r.st        = ST_RACK;
                        end
                    end
                    ST_RACK: begin
                        if (!lnk.sda) begin
                            // Master acked: sample the next byte now.
                            next_r.sh        = pin_byte;
                            next_r.snap      = r.pin_s2;
                            next_r.hi        = ~r.hi;
                            next_r.drive_nxt = ~pin_byte[7];
                            next_r.bit_cnt   = 3'h0;
                            next_r.st        = ST_RDATA;
                        end else begin
                            next_r.st        = ST_IDLE;
                            next_r.drive_nxt = 1'b0;
                        end
                    end
                    default: begin
                        next_r.st        = ST_IDLE;
                        next_r.drive_nxt = 1'b0;
                    end
                endcase
            end
        end
    end

    // Reset leaves the bus idle and every line high on the weak pullup.
    always_ff @(posedge lnk.scl or negedge rstn) begin
        if (!rstn) begin
            r        <= '0;
            r.st     <= ST_IDLE;
            r.latch  <= qpx_pkg::PORT_RESET;
            r.snap   <= qpx_pkg::PORT_RESET;
            r.pin_s1 <= qpx_pkg::PORT_RESET;
            r.pin_s2 <= qpx_pkg::PORT_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Any line that differs from the snapshot raises the interrupt.
    assign int_raw = |(port_lines_in ^ r.snap);

    // During the high half of a write ack the old level holds until SCL falls.
    assign lnk.int_oe = (r.wr_clr && lnk.scl) ? int_hold : int_raw;

    // Zero bits sink hard; freshly written ones get a brief strong pullup.
    assign port_lines_drive_low  = ~r.latch;
    assign port_lines_strong_up  = r.latch & {qpx_pkg::PORT_W{r.upd_tgl ^ upd_seen}};
    assign lnk.s_sda_oe          = sda_oe;
endmodule : qpx_expander
`default_nettype wire

// ==== rtl/qpx_link_if.sv ====
// Two-wire bus plus interrupt line joining the master and the expander.
`timescale 1ns/10ps
`default_nettype none
interface qpx_link_if;
    logic scl_oe;
    logic m_sda_oe;
    logic s_sda_oe;
    logic int_oe;
    logic scl;
    logic sda;
    logic int_n;

    // Open-drain wires: a line is low while any party enables its driver.
    assign scl   = ~scl_oe;
    assign sda   = ~(m_sda_oe | s_sda_oe);
    assign int_n = ~int_oe;

    modport master (output scl_oe, output m_sda_oe, input scl, input sda, input int_n);
    modport device (output s_sda_oe, output int_oe, input scl, input sda);
endinterface : qpx_link_if
`default_nettype wire

// ==== rtl/qpx_master.sv ====
// Bus master end: makes SCL by division and moves byte pairs to and from the expander.
`timescale 1ns/10ps
`default_nettype none
module qpx_master #(
    parameter int QTR = qpx_pkg::QTR_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    qpx_link_if.master       lnk,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic [2:0]  cmd_addr_sel,
    input  wire logic [7:0]  cmd_pairs,
    input  wire logic [15:0] wr_word,
    output logic             wr_take,
    output logic [15:0]      rd_word,
    output logic             rd_valid,
    output logic             done,
    output logic             nacked,
    output logic             int_pending
);
    localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

    typedef enum logic [1:0] {
        M_IDLE,
        M_START,
        M_BIT,
        M_STOP
    } qpx_mst_st_t;

    typedef struct packed {
        qpx_mst_st_t st;
        logic [7:0]  div;
        logic [1:0]  qtr;
        logic [3:0]  bit_i;
        logic [8:0]  byte_i;
        logic [8:0]  last;
        logic        rd;
        logic [7:0]  tx;
        logic [15:0] word;
        logic [15:0] rx;
        logic        scl_oe;
        logic        sda_oe;
        logic        sda_s1;
        logic        sda_s2;
        logic        int_s1;
        logic        int_s2;
        logic        wr_take;
        logic        rd_valid;
        logic        done;
        logic        nacked;
    } qpx_mst_t;

    qpx_mst_t r;
    qpx_mst_t next_r;
    logic     tick;
    logic     data_rd;

    assign tick    = (r.div == QTR_LAST);
    assign data_rd = r.rd && (r.byte_i != 9'h000);

    // Quarter-bit sequencer: phases 0-1 SCL low, phases 2-3 SCL high.
    always_comb begin
        next_r = r;
        if (ce) begin
            next_r.sda_s1   = lnk.sda;
            next_r.sda_s2   = r.sda_s1;
            next_r.int_s1   = lnk.int_n;
            next_r.int_s2   = r.int_s1;
            next_r.wr_take  = 1'b0;
            next_r.rd_valid = 1'b0;
            next_r.done     = 1'b0;
            if (r.st != M_IDLE) begin
                next_r.div = tick ? 8'h00 : r.div + 8'h01;
                if (tick) begin
                    next_r.qtr = r.qtr + 2'h1;
                end
            end
            case (r.st)
                M_IDLE: begin
                    if (cmd_valid) begin
                        next_r.st     = M_START;
                        next_r.rd     = cmd_read;
                        next_r.last   = {cmd_pairs, 1'b0};
                        next_r.byte_i = 9'h000;
                        next_r.bit_i  = 4'h0;
                        next_r.qtr    = 2'h0;
                        next_r.div    = 8'h00;
                        next_r.nacked = 1'b0;
                        next_r.tx     = {qpx_pkg::ADDR_FIXED, cmd_addr_sel, cmd_read};
                    end
                end
                M_START: begin
                    if (tick && r.qtr == 2'h1) begin
                        next_r.sda_oe = 1'b1;
                    end
                    if (tick && r.qtr == 2'h3) begin
                        next_r.scl_oe = 1'b1;
                        next_r.st     = M_BIT;
                    end
                end
                M_BIT: begin
                    if (tick) begin
                        case (r.qtr)
                            2'h0: begin
                                // Drive only while SCL is low.
                                if (r.bit_i != 4'h8) begin
                                    next_r.sda_oe = data_rd ? 1'b0 : ~r.tx[7];
                                end else begin
                                    next_r.sda_oe = data_rd && (r.byte_i != r.last);
                                end
                            end
                            2'h1: begin
                                next_r.scl_oe = 1'b0;
                            end
                            2'h2: begin
                                next_r.scl_oe = 1'b0;
                            end
                            default: begin
                                next_r.scl_oe = 1'b1;
                                if (r.bit_i != 4'h8) begin
                                    next_r.rx    = {r.rx[14:0], r.sda_s2};
                                    next_r.tx    = {r.tx[6:0], 1'b0};
                                    next_r.bit_i = r.bit_i + 4'h1;
                                end else begin
                                    next_r.bit_i = 4'h0;
                                    if (data_rd && !r.byte_i[0]) begin
                                        next_r.word     = {r.rx[7:0], r.rx[15:8]};
                                        next_r.rd_valid = 1'b1;
                                    end
                                    if (!data_rd && r.sda_s2) begin
                                        next_r.nacked = 1'b1;
                                        next_r.st     = M_STOP;
                                    end else if (r.byte_i == r.last) begin
                                        next_r.st = M_STOP;
                                    end else begin
                                        next_r.byte_i = r.byte_i + 9'h001;
                                        if (!r.rd && !r.byte_i[0]) begin
                                            next_r.tx      = wr_word[7:0];
                                            next_r.word    = wr_word;
                                            next_r.wr_take = 1'b1;
                                        end else if (!r.rd) begin
                                            next_r.tx = r.word[15:8];
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        case (r.qtr)
                            2'h0: next_r.sda_oe = 1'b1;
                            2'h1: next_r.scl_oe = 1'b0;
                            2'h2: next_r.sda_oe = 1'b0;
                            default: begin
                                next_r.st   = M_IDLE;
                                next_r.done = 1'b1;
                            end
                        endcase
                    end
                end
                default: begin
                    next_r.st = M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r        <= '0;
            r.st     <= M_IDLE;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.int_s1 <= 1'b1;
            r.int_s2 <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign cmd_ready    = (r.st == M_IDLE);
    assign lnk.scl_oe   = r.scl_oe;
    assign lnk.m_sda_oe = r.sda_oe;
    assign wr_take      = r.wr_take;
    assign rd_word      = r.word;
    assign rd_valid     = r.rd_valid;
    assign done         = r.done;
    assign nacked       = r.nacked;
    assign int_pending  = ~r.int_s2;
endmodule : qpx_master
`default_nettype wire

// ==== rtl/qpx_pkg.sv ====
// Shared constants for the quasi-bidirectional port expander and its bus master.
package qpx_pkg;
    localparam int          PORT_W     = 16;
    localparam logic [3:0]  ADDR_FIXED = 4'h4;
    localparam logic [6:0]  ADDR_GCALL = 7'h00;
    localparam logic [15:0] PORT_RESET = 16'hFFFF;
    localparam int          CLK_KHZ    = 50000;
    localparam int          SCL_KHZ    = 400;
    // Quarter of one bus bit in system clocks, rounded up so no phase runs short.
    localparam int          QTR_CYC    = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
endpackage : qpx_pkg

// ==== rtl/qpx_scl_neg.sv ====
// Falling-edge helpers of the expander: data drive, pullup end and Start detection.
`timescale 1ns/10ps
`default_nettype none
module qpx_scl_neg (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic drive_nxt,
    input  wire logic upd_tgl,
    input  wire logic int_raw,
    output logic      sda_oe,
    output logic      upd_seen,
    output logic      int_hold,
    output logic      start_tgl
);
    typedef struct packed {
        logic sda_oe;
        logic upd_seen;
        logic int_hold;
    } qpx_neg_t;

    qpx_neg_t r;
    qpx_neg_t next_r;

    // SDA only changes while SCL is low; the strong pullup ends at this edge.
    always_comb begin
        next_r = r;
        if (ce) begin
            next_r.sda_oe   = drive_nxt;
            next_r.upd_seen = upd_tgl;
            next_r.int_hold = int_raw;
        end
    end

    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // A falling SDA while SCL is high is a Start; the toggle marks each one.
    always_ff @(negedge sda or negedge rstn) begin
        if (!rstn) begin
            start_tgl <= 1'b0;
        end else if (ce && scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    assign sda_oe   = r.sda_oe;
    assign upd_seen = r.upd_seen;
    assign int_hold = r.int_hold;
endmodule : qpx_scl_neg
`default_nettype wire

// ==== verif/i2c_quasi_bidir_port_expander_test.sv ====
// Self-checking bench joining the bus master and the port expander.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module i2c_quasi_bidir_port_expander_test;
    typedef struct packed {
        logic        rd;
        logic [2:0]  sel, pins;
        logic [7:0]  pairs;
        logic [15:0] w0, w1, ext, drv, su;
        logic        nk;
    } qpx_row_t;
    localparam qpx_row_t ROWS [6] = '{
        '{1'h0,3'h0,3'h0,8'h01,16'h12F0,16'h0000,16'h0000,16'hED0F,16'h12F0,1'h0},
        '{1'h0,3'h5,3'h5,8'h02,16'hA55A,16'h00FF,16'h0000,16'hFF00,16'hA5FF,1'h0},
        '{1'h0,3'h3,3'h5,8'h01,16'h0000,16'h0000,16'h0000,16'hFF00,16'h0000,1'h1},
        '{1'h0,3'h5,3'h5,8'h00,16'h0000,16'h0000,16'h0000,16'hFF00,16'h0000,1'h0},
        '{1'h0,3'h5,3'h5,8'h01,16'hFFFF,16'h0000,16'h0000,16'h0000,16'hFFFF,1'h0},
        '{1'h1,3'h5,3'h5,8'h01,16'h0000,16'h0000,16'h0081,16'h0000,16'h0000,1'h0}};
    logic        clk, rstn, cmd_valid, cmd_read, cmd_ready, wr_take, rd_valid, done;
    logic        nacked, int_pending, clr, widx;
    logic [2:0]  cmd_addr_sel, addr_select_pins;
    logic [7:0]  cmd_pairs;
    logic [15:0] w0, w1, ext, wr_word, rd_word, port_lines_drive_low, port_lines_strong_up;
    logic [15:0] su_seen;
    logic [7:0]  rdv_n;
    int          fail_count, comparisons;
    // Pins sit high on the weak pullup unless the expander or the outside pulls them low.
    wire logic [15:0] port_lines_in = ~port_lines_drive_low & ~ext;
    assign wr_word = widx ? w1 : w0;
    qpx_link_if qpx_link_if_i ();
    qpx_master #(.QTR(4)) qpx_master_i (.clk, .rstn, .ce(1'h1), .lnk(qpx_link_if_i.master),
        .cmd_valid, .cmd_ready, .cmd_read, .cmd_addr_sel, .cmd_pairs, .wr_word, .wr_take,
        .rd_word, .rd_valid, .done, .nacked, .int_pending);
    qpx_expander qpx_expander_i (.lnk(qpx_link_if_i.device), .rstn, .ce(1'h1),
        .addr_select_pins, .port_lines_in, .port_lines_drive_low, .port_lines_strong_up);
    qpx_link_props qpx_link_props_i (.clk, .rstn, .s_sda_oe(qpx_link_if_i.s_sda_oe),
        .scl(qpx_link_if_i.scl), .sda(qpx_link_if_i.sda));

    // Makes the 50 MHz system clock.
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Collects strong pullup pulses, counts read words and steps to the next word at each take.
    always @(posedge clk) begin
        su_seen <= clr ? 16'h0000 : su_seen | port_lines_strong_up;
        rdv_n   <= clr ? 8'h00 : rdv_n + 8'(rd_valid);
        widx    <= clr ? 1'h0 : widx ^ wr_take;
    end

    task automatic conclude();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Issues one command and waits a bounded time for its completion pulse.
    task automatic run(input logic rd, input logic [2:0] sel, input logic [7:0] pairs);
        int n = 0;
        @(posedge clk);
        cmd_valid    <= 1'h1;
        cmd_read     <= rd;
        cmd_addr_sel <= sel;
        cmd_pairs    <= pairs;
        clr          <= 1'h1;
        @(posedge clk);
        cmd_valid <= 1'h0;
        clr       <= 1'h0;
        while (done !== 1'h1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 5000) fail_count++;
    endtask : run

    // Changes the outside pull and lets the interrupt pass the master's synchroniser.
    task automatic set_ext(input logic [15:0] v);
        @(posedge clk);
        ext <= v;
        repeat (4) @(posedge clk);
        #1;
    endtask : set_ext

    // Main sequence: reset, table rows, then interrupt cases and a reset between runs.
    initial begin
        {rstn, cmd_valid, cmd_read, clr, cmd_addr_sel, addr_select_pins} <= 10'h000;
        {cmd_pairs, ext, w0, w1} = 56'h0;
        fail_count = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'h1;
        #1;
        `CHK(port_lines_drive_low, 16'h0000)
        `CHK(port_lines_strong_up, 16'h0000)
        foreach (ROWS[i]) begin
            @(posedge clk);
            addr_select_pins <= ROWS[i].pins;
            ext <= ROWS[i].ext;
            w0 <= ROWS[i].w0;
            w1 <= ROWS[i].w1;
            run(ROWS[i].rd, ROWS[i].sel, ROWS[i].pairs);
            `CHK(nacked, ROWS[i].nk)
            `CHK(port_lines_drive_low, ROWS[i].drv)
            `CHK(su_seen, ROWS[i].su)
            `CHK(port_lines_strong_up, 16'h0000)
            if (ROWS[i].rd) `CHK(rd_word, ~ROWS[i].ext)
            if (ROWS[i].rd) `CHK(rdv_n, ROWS[i].pairs)
            `CHK(int_pending, 1'h0)
        end
        `CHK(int_pending, 1'h0)
        set_ext(16'h0000);
        `CHK(int_pending, 1'h1)
        run(1'h0, 3'h2, 8'h01);
        `CHK(int_pending, 1'h1)
        set_ext(16'h0081);
        `CHK(int_pending, 1'h0)
        set_ext(16'h0000);
        `CHK(int_pending, 1'h1)
        run(1'h0, 3'h5, 8'h01);
        `CHK(int_pending, 1'h0)
        `CHK(port_lines_drive_low, 16'hFFFF)
        @(posedge clk);
        rstn <= 1'h0;
        repeat (10) @(posedge clk);
        #1;
        `CHK(port_lines_drive_low, 16'h0000)
        @(posedge clk);
        rstn <= 1'h1;
        run(1'h1, 3'h5, 8'h02);
        `CHK(rd_word, 16'hFFFF)
        `CHK(rdv_n, 8'h02)
        conclude();
    end

    // Cuts a hung run short.
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule : i2c_quasi_bidir_port_expander_test
`default_nettype wire

// ==== verif/qpx_link_props.sv ====
// Assertions on the expander side of the two-wire link.
`timescale 1ns/10ps
`default_nettype none
module qpx_link_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q, sda_q, dat, rw, acked, nk;
    logic [3:0] bitn;
    logic [7:0] sh;
    wire        rise = scl & ~scl_q;
    wire        ack  = rise & (bitn == 4'h8);

    // Follows bit and byte position from the sampled bus so checks know the phase.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {scl_q, sda_q, dat, rw, acked, nk, bitn, sh} <= 18'h30000;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) begin
                {bitn, dat, acked, nk} <= 7'h00;
            end else if (ack) begin
                bitn <= 4'h0;
                dat  <= 1'h1;
                if (!dat) {rw, acked} <= {sh[0], ~sda};
                nk   <= nk | (dat & rw & acked & sda);
            end else if (rise) begin
                bitn <= bitn + 4'h1;
                sh   <= {sh[6:0], sda};
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence ack_addr; ack && !dat; endsequence
    sequence ack_data; ack && dat && acked; endsequence

    AST_GCALL_NO_ACK: assert property (ack_addr ##0 sh == 8'h00 |-> !s_sda_oe)
        else $error("general call acknowledged");
    AST_ACK_OWN_PREFIX: assert property (ack_addr ##0 s_sda_oe |-> sh[7:4] == 4'h4)
        else $error("acknowledged an address outside the fixed prefix");
    AST_WRITE_BYTE_ACK: assert property (ack_data ##0 !rw |-> s_sda_oe)
        else $error("write byte not acknowledged");
    AST_RECEIVE_QUIET: assert property (rise && !ack && (!dat || !rw || !acked) |-> !s_sda_oe)
        else $error("expander drove data while receiving");
    AST_NACK_RELEASE: assert property (nk |-> !s_sda_oe)
        else $error("data line held after master nack");
    AST_HOLD_WHILE_HIGH: assert property (scl && scl_q |-> $stable(s_sda_oe))
        else $error("expander moved data while clock high");
    AST_DRIVE_ON_FALL: assert property ($changed(s_sda_oe) |-> scl_q && !scl)
        else $error("expander data changed away from a clock fall");
    AST_RESET_IDLE: assert property ($rose(rstn) |-> !s_sda_oe [*8])
        else $error("expander not idle after reset");
endmodule : qpx_link_props
`default_nettype wire
